// ==== synth_prog.sv ====
// Serial programming front end and word decoder of a dual-PLL clock synthesizer
`timescale 1ns/1ps
// How it works
// - Unlock needs five or more data-high rising clocks, then one data-low rising clock.
// - Serial activity is ignored entirely while power-down is asserted.
// - Any pin transition restarts a 2ms watchdog; expiry drops unlock and word.
// - Select pins reach the output-select decode only after watchdog expiry.
// - Order is start bit, 21 data bits, 3 address bits, stop bit.
// - Load with fewer than 24 shifted bits is rejected with an error.
// - Data high across fall and rise loads addressed register, clears unlock.
// - Bits beyond a full register without stop discard the word with error.
// - After a load, pins resume selection only after a watchdog time-out.
// - Error output goes low on error and stays low until next unlock.
// - Errors: bad start, bad complement, wrong length, bad stop.
// - Control bit 21 picks power-down mode, default 0.
// - Control bit 20 picks clock on video output during changes, default 0.
// - Control bit 19 doubles the time-out interval, default 0.
// - Control bit 17 trims duty cycle, default 1.
// - Control bits 15..13 pick prescale 2 or 4 for video registers 2..0.
// - Frequency word: index 4, feedback 7, divider select 3, reference 7 bits.
// - Feedback divider is field plus 3, reference divider field plus 2.
// - Output divider is two to the power of the 3-bit select.
// - Video index 1110 turns video off, 1111 routes memory VCO to video.
// - Addresses 000..010 video, 011 memory, 100 standby, 110 control.
// - Reprogramming memory, or the active video register under select codes 00..10, routes reference there until settled.
module synth_prog
   import synth_prog_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        serial_clock_select_low,
   input  wire logic        serial_data_select_high,
   input  wire logic        powerdown_n,
   output logic             program_error_n,
   output logic [1:0]       video_select,
   output logic             pd_mode_sel,
   output logic             change_mux_sel,
   output logic             timeout_double,
   output logic             duty_trim_n,
   output logic [2:0]       prescale_sel,
   output logic [2:0]       video_prescale_x4,
   output logic [7:0]       video_fb_div,
   output logic [7:0]       video_ref_div,
   output logic [2:0]       video_out_div_log2,
   output logic             video_off,
   output logic             video_from_memory,
   output logic [7:0]       memory_fb_div,
   output logic [7:0]       memory_ref_div,
   output logic [2:0]       memory_out_div_log2,
   output logic [3:0]       standby_code,
   output logic             ref_on_video,
   output logic             ref_on_memory
);

   typedef enum logic [1:0] {ST_LOCKED, ST_START, ST_SHIFT, ST_STOP} prog_state_t;

   // Feedback divider from a frequency word
   function automatic logic [7:0] fb_div(input logic [20:0] w);
      fb_div = {1'b0, w[F_FB_LSB +: 7]} + FB_OFFSET;
   endfunction

   // Reference divider from a frequency word
   function automatic logic [7:0] ref_div(input logic [20:0] w);
      ref_div = {1'b0, w[F_REF_LSB +: 7]} + REF_OFFSET;
   endfunction

   // ==========================================================
   // Pin edge detection
   logic        sck_q;
   logic        sda_q;
   logic        sck_rise;
   logic        sck_fall;
   logic        pins_moved;
   logic        active;

   // Power-down masks every pin edge from the serial engine and the watchdog
   assign active     = powerdown_n;
   assign sck_rise   = active && serial_clock_select_low && !sck_q;
   assign sck_fall   = active && !serial_clock_select_low && sck_q;
   assign pins_moved = active && ((serial_clock_select_low != sck_q) ||
                                  (serial_data_select_high != sda_q));

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sck_q <= 1'b0;
         sda_q <= 1'b0;
      end else begin
         sck_q <= serial_clock_select_low;
         sda_q <= serial_data_select_high;
      end
   end

   // ==========================================================
   // Watchdog, doubled interval selectable
   logic [20:0] wd_count;
   logic        wd_expired;
   logic [20:0] wd_limit;

   assign wd_limit = timeout_double ? 21'(2 * WATCHDOG_CYCLES) : 21'(WATCHDOG_CYCLES);

   // Any edge restarts the count; expiry is a one-cycle pulse at the limit
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wd_count <= 21'h0;
      end else if (pins_moved) begin
         wd_count <= 21'h0;
      end else begin
         wd_count <= (wd_count < wd_limit) ? wd_count + 21'h1 : 21'h0;
      end
   end

   assign wd_expired = (wd_count == wd_limit);

   // ==========================================================
   // Unlock detector and serial word engine
   prog_state_t state;
   logic [2:0]  ones_count;
   logic [4:0]  bit_count;
   logic [23:0] shift_word;
   logic        comp_bit;
   logic        comp_valid;
   logic        load_pulse;
   logic        err_event;

   // Complement half of each bit is caught on the falling edge
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         comp_bit   <= 1'b0;
         comp_valid <= 1'b0;
      end else if (sck_fall) begin
         comp_bit   <= serial_data_select_high;
         comp_valid <= 1'b1;
      end else if (sck_rise || state == ST_LOCKED) begin
         comp_valid <= 1'b0;
      end
   end

   // Data-high rising edges counted toward unlock; saturates at five
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ones_count <= 3'h0;
      end else if (state != ST_LOCKED || wd_expired) begin
         ones_count <= 3'h0;
      end else if (sck_rise) begin
         if (!serial_data_select_high) begin
            ones_count <= 3'h0;
         end else if (ones_count != 3'(UNLOCK_MIN_ONES)) begin
            ones_count <= ones_count + 3'h1;
         end
      end
   end

   // Main sequence: start, 24 shifted bits, stop/load
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state      <= ST_LOCKED;
         bit_count  <= 5'h0;
         shift_word <= 24'h0;
         load_pulse <= 1'b0;
         err_event  <= 1'b0;
      end else begin
         load_pulse <= 1'b0;
         err_event  <= 1'b0;
         if (wd_expired && state != ST_LOCKED) begin
            state <= ST_LOCKED;
         end else if (sck_rise) begin
            case (state)
               ST_LOCKED: begin
                  if (!serial_data_select_high &&
                      ones_count == 3'(UNLOCK_MIN_ONES)) begin
                     state     <= ST_START;
                     bit_count <= 5'h0;
                  end
               end
               ST_START: begin
                  // Start bit is a zero, coded like a data bit
                  if (serial_data_select_high || !comp_valid || !comp_bit) begin
                     state     <= ST_LOCKED;
                     err_event <= 1'b1;
                  end else begin
                     state <= ST_SHIFT;
                  end
               end
               ST_SHIFT: begin
                  if (serial_data_select_high && comp_valid && comp_bit) begin
                     // Stop pattern before the word is full
                     state     <= ST_LOCKED;
                     err_event <= 1'b1;
                  end else if (!comp_valid || comp_bit == serial_data_select_high) begin
                     state     <= ST_LOCKED;
                     err_event <= 1'b1;
                  end else begin
                     shift_word <= {shift_word[22:0], serial_data_select_high};
                     bit_count  <= bit_count + 5'h1;
                     if (bit_count == 5'(WORD_BITS - 1)) begin
                        state <= ST_STOP;
                     end
                  end
               end
               ST_STOP: begin
                  state <= ST_LOCKED;
                  if (serial_data_select_high && comp_valid && comp_bit) begin
                     load_pulse <= 1'b1;
                  end else begin
                     err_event <= 1'b1;
                  end
               end
               default: begin
                  state <= ST_LOCKED;
               end
            endcase
         end
      end
   end

   // Error pin: low from any error until the next unlock completes
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         program_error_n <= 1'b1;
      end else if (err_event) begin
         program_error_n <= 1'b0;
      end else if (state == ST_LOCKED && sck_rise && !serial_data_select_high &&
                   ones_count == 3'(UNLOCK_MIN_ONES)) begin
         program_error_n <= 1'b1;
      end
   end

   // ==========================================================
   // Register file
   logic [20:0] video_word [3];
   logic [20:0] memory_word;
   logic [21:0] control_word;
   logic [2:0]  load_addr;
   logic [20:0] load_data;

   assign load_addr = shift_word[2:0];
   assign load_data = shift_word[23:3];

   // Video registers; undefined addresses fall through untouched
   genvar gv;
   generate
      for (gv = 0; gv < 3; gv++) begin : g_video
         always_ff @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               video_word[gv] <= FREQ_RESET;
            end else if (load_pulse && load_addr == 3'(gv)) begin
               video_word[gv] <= load_data;
            end
         end
      end
   endgenerate

   // Memory, standby and control registers; 101 and 111 load nothing
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memory_word  <= FREQ_RESET;
         standby_code <= STANDBY_RESET;
         control_word <= {1'b0, CTL_RESET};
      end else if (load_pulse) begin
         case (load_addr)
            ADDR_MEMORY:  memory_word  <= load_data;
            ADDR_STANDBY: standby_code <= load_data[3:0];
            ADDR_CONTROL: control_word <= {load_data, 1'b0}; // Data bit n is control bit n+1
            default: ;
         endcase
      end
   end

   // ==========================================================
   // Select pins pass to the decode only once the serial pins have gone quiet
   logic sel_quiet;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         sel_quiet    <= 1'b0;
         video_select <= 2'h0;
      end else begin
         if (pins_moved) begin
            sel_quiet <= 1'b0;
         end else if (wd_expired) begin
            sel_quiet <= 1'b1;
         end
         // A load is followed by a full time-out before selection resumes
         if (!sel_quiet && wd_expired && state == ST_LOCKED) begin
            video_select <= {sda_q, sck_q};
         end
      end
   end

   // ==========================================================
   // Decoded control and frequency outputs
   logic [20:0] active_video;

   // Selection code 11 also maps to the third video register
   assign active_video = video_word[(video_select == 2'h3) ? 2 : video_select];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pd_mode_sel       <= 1'b0;
         change_mux_sel    <= 1'b0;
         timeout_double    <= 1'b0;
         duty_trim_n       <= 1'b1;
         prescale_sel      <= 3'h0;
         video_prescale_x4 <= 1'b0 ? 3'h0 : 3'h0;
      end else begin
         pd_mode_sel    <= control_word[CTL_PD_MODE];
         change_mux_sel <= control_word[CTL_CHG_MUX];
         timeout_double <= control_word[CTL_TO_DOUBLE];
         duty_trim_n    <= control_word[CTL_DUTY_N];
         // Reserved bits 18 and 16 are stored but steer nothing
         prescale_sel   <= {control_word[CTL_PRE_V2], control_word[CTL_PRE_V1],
                            control_word[CTL_PRE_V0]};
         video_prescale_x4 <= {3{control_word[CTL_PRE_V0 + 32'(video_select == 2'h3 ?
                               2 : video_select)]}};
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         video_fb_div        <= FB_OFFSET;
         video_ref_div       <= REF_OFFSET;
         video_out_div_log2  <= 3'h0;
         video_off           <= 1'b0;
         video_from_memory   <= 1'b0;
         memory_fb_div       <= FB_OFFSET;
         memory_ref_div      <= REF_OFFSET;
         memory_out_div_log2 <= 3'h0;
      end else begin
         video_fb_div        <= fb_div(active_video);
         video_ref_div       <= ref_div(active_video);
         video_out_div_log2  <= active_video[F_MUX_LSB +: 3];
         video_off           <= active_video[F_IDX_LSB +: 4] == IDX_VIDEO_OFF;
         video_from_memory   <= active_video[F_IDX_LSB +: 4] == IDX_VIDEO_MEM;
         memory_fb_div       <= fb_div(memory_word);
         memory_ref_div      <= ref_div(memory_word);
         memory_out_div_log2 <= memory_word[F_MUX_LSB +: 3];
      end
   end

   // ==========================================================
   // Reference takes over a reprogrammed output for two time-outs
   logic [1:0] vid_hold;
   logic [1:0] mem_hold;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         vid_hold      <= 2'h0;
         mem_hold      <= 2'h0;
         ref_on_video  <= 1'b0;
         ref_on_memory <= 1'b0;
      end else begin
         if (load_pulse && load_addr == {1'b0, video_select}) begin
            vid_hold <= 2'h2;
         end else if (wd_expired && vid_hold != 2'h0) begin
            vid_hold <= vid_hold - 2'h1;
         end
         if (load_pulse && load_addr == ADDR_MEMORY) begin
            mem_hold <= 2'h2;
         end else if (wd_expired && mem_hold != 2'h0) begin
            mem_hold <= mem_hold - 2'h1;
         end
         ref_on_video  <= vid_hold != 2'h0;
         ref_on_memory <= mem_hold != 2'h0;
      end
   end

endmodule

// ==== synth_prog_pkg.sv ====
// Constants, field layouts and timing for the serial synthesizer programmer
package synth_prog_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_HZ            = 100_000_000;
   localparam int unsigned WATCHDOG_US       = 2000;     // 2ms
   localparam int unsigned WATCHDOG_CYCLES   = (WATCHDOG_US * (CLK_HZ / 1_000_000));
   localparam int unsigned UNLOCK_MIN_ONES   = 5;
   localparam int unsigned WORD_BITS         = 24;
   localparam int unsigned DATA_BITS         = 21;
   localparam int unsigned ADDR_BITS         = 3;
   // ==========================================================
   // Register addresses
   localparam logic [2:0] ADDR_VIDEO0   = 3'h0;
   localparam logic [2:0] ADDR_VIDEO1   = 3'h1;
   localparam logic [2:0] ADDR_VIDEO2   = 3'h2;
   localparam logic [2:0] ADDR_MEMORY   = 3'h3;
   localparam logic [2:0] ADDR_STANDBY  = 3'h4;
   localparam logic [2:0] ADDR_CONTROL  = 3'h6;
   // ==========================================================
   // Control register fields
   localparam int unsigned CTL_PD_MODE   = 21;
   localparam int unsigned CTL_CHG_MUX   = 20;
   localparam int unsigned CTL_TO_DOUBLE = 19;
   localparam int unsigned CTL_RSV_HI    = 18;
   localparam int unsigned CTL_DUTY_N    = 17;
   localparam int unsigned CTL_RSV_LO    = 16;
   localparam int unsigned CTL_PRE_V2    = 15;
   localparam int unsigned CTL_PRE_V1    = 14;
   localparam int unsigned CTL_PRE_V0    = 13;
   localparam logic [20:0] CTL_RESET     = 21'h020000;
   // ==========================================================
   // Frequency word fields (LSB at bit 0)
   localparam int unsigned F_REF_LSB  = 0;
   localparam int unsigned F_MUX_LSB  = 7;
   localparam int unsigned F_FB_LSB   = 10;
   localparam int unsigned F_IDX_LSB  = 17;
   localparam logic [3:0]  IDX_VIDEO_OFF = 4'he;
   localparam logic [3:0]  IDX_VIDEO_MEM = 4'hf;
   localparam logic [7:0]  FB_OFFSET     = 8'h03;
   localparam logic [7:0]  REF_OFFSET    = 8'h02;
   localparam logic [3:0]  STANDBY_RESET = 4'h8;
   localparam logic [20:0] FREQ_RESET    = 21'h000000;
endpackage

// ==== synth_prog_monitor.sv ====
// Port-level checker for the serial synthesizer programmer
`timescale 1ns/1ps
module synth_prog_monitor
   import synth_prog_pkg::*;
(
   input wire logic       clk_sys,
   input wire logic       rst,
   input wire logic       serial_clock_select_low,
   input wire logic       serial_data_select_high,
   input wire logic       powerdown_n,
   input wire logic       program_error_n,
   input wire logic [1:0] video_select,
   input wire logic       duty_trim_n,
   input wire logic [2:0] prescale_sel,
   input wire logic [7:0] video_ref_div,
   input wire logic       video_off,
   input wire logic       video_from_memory,
   input wire logic [7:0] memory_fb_div,
   input wire logic [3:0] standby_code
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // ==========================================================
   // Pin history
   logic        clk_q;
   logic        dat_q;
   logic        rise;
   logic [3:0]  since_rise;
   logic [3:0]  since_unlock;
   logic [18:0] quiet;
   assign rise = serial_clock_select_low && !clk_q;
   // Saturating counts, so a long idle never wraps into a false cause
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         clk_q        <= 1'b0;
         dat_q        <= 1'b0;
         since_rise   <= 4'hf;
         since_unlock <= 4'hf;
         quiet        <= 19'h00000;
      end else begin
         clk_q        <= serial_clock_select_low;
         dat_q        <= serial_data_select_high;
         since_rise   <= rise ? 4'h0 : since_rise + {3'h0, since_rise != 4'hf};
         since_unlock <= (rise && !serial_data_select_high) ? 4'h0 :
                         since_unlock + {3'h0, since_unlock != 4'hf};
         quiet        <= (rise || serial_clock_select_low != clk_q ||
                          serial_data_select_high != dat_q) ?
                         19'h00000 : quiet + {18'h0, quiet != 19'h7ffff};
      end
   end
   // ==========================================================
   // Assertions
   err_clear_a: assert property ($rose(program_error_n) |-> since_unlock <= 4'h4)
      else $error("error output released without an unlock edge");
   err_cause_a: assert property ($fell(program_error_n) |-> since_rise <= 4'h5 && powerdown_n)
      else $error("error output fell without a serial clock rise");
   pd_freeze_a: assert property ((!powerdown_n) [*4] |=> $stable(program_error_n)
      && $stable(memory_fb_div) && $stable(standby_code))
      else $error("state changed during power-down");
   sel_quiet_a: assert property (!$stable(video_select) |-> quiet >= 19'(WATCHDOG_CYCLES - 8))
      else $error("video selection moved before the pins were quiet");
   mem_load_a: assert property (!$stable(memory_fb_div) |-> since_rise <= 4'h5)
      else $error("memory divider changed without a load edge");
   ctl_load_a: assert property (!$stable(duty_trim_n) || !$stable(prescale_sel) |-> since_rise <= 4'h5)
      else $error("control bits changed without a load edge");
   stby_load_a: assert property (!$stable(standby_code) |-> since_rise <= 4'h5)
      else $error("standby code changed without a load edge");
   video_index_a: assert property (!(video_off && video_from_memory))
      else $error("video off and memory routing both set");
   fb_range_a: assert property (memory_fb_div != 8'h00 |-> memory_fb_div inside {[8'h03:8'h82]})
      else $error("feedback divider out of range");
   ref_range_a: assert property (video_ref_div != 8'h00 |-> video_ref_div inside {[8'h02:8'h81]})
      else $error("reference divider out of range");
endmodule
bind synth_prog synth_prog_monitor i_synth_prog_monitor (.*);

// ==== synth_host.sv ====
// Host model driving the shared serial clock and data pins
`timescale 1ns/1ps
module synth_host (
   input  wire logic clk_sys,
   output logic      serial_clock_select_low,
   output logic      serial_data_select_high
);
   // Pins rest at the pull-down level outside programming
   initial begin
      serial_clock_select_low = 1'b0;
      serial_data_select_high = 1'b0;
   end
   // ==========================================================
   // One pin step, held five clocks; far inside the watchdog limit
   task automatic pin(input logic c, input logic d);
      @(negedge clk_sys);
      serial_clock_select_low = c;
      serial_data_select_high = d;
      repeat (4) @(negedge clk_sys);
   endtask
   // Clock rises with data high, then one rise with data low
   task automatic unlock(input int ones);
      pin(1'b0, 1'b1);
      repeat (ones) begin
         pin(1'b1, 1'b1);
         pin(1'b0, 1'b1);
      end
      pin(1'b0, 1'b0);
      pin(1'b1, 1'b0);
   endtask
   // Level at the fall, level at the rise; a true bit b is coded(~b, b)
   task automatic coded(input logic f, input logic r);
      pin(1'b1, f);
      pin(1'b0, f);
      pin(1'b0, r);
      pin(1'b1, r);
   endtask
   // Start bit, then n word bits, most significant first
   task automatic frame(input logic [23:0] w, input int n);
      coded(1'b1, 1'b0);
      for (int i = 0; i < n; i++) coded(~w[23 - i], w[23 - i]);
   endtask
   // Release data, then clock
   task automatic idle();
      pin(1'b1, 1'b0);
      pin(1'b0, 1'b0);
   endtask
endmodule

// ==== synth_prog_tb.sv ====
// Self-checking testbench for the serial synthesizer programmer
`timescale 1ns/1ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin err_count++; \
   $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp); end end
module synth_prog_tb
   import synth_prog_pkg::*;
;
   logic       clk_sys, rst, powerdown_n, program_error_n, pd_mode_sel, change_mux_sel;
   logic       timeout_double, duty_trim_n, video_off, video_from_memory;
   logic       ref_on_video, ref_on_memory, serial_clock_select_low, serial_data_select_high;
   logic [1:0] video_select;
   logic [2:0] prescale_sel, video_prescale_x4, video_out_div_log2, memory_out_div_log2;
   logic [3:0] standby_code;
   logic [7:0] video_fb_div, video_ref_div, memory_fb_div, memory_ref_div;
   int         err_count;
   int         check_count;
   int         regs [8];
   logic       err_exp;
   synth_prog i_synth_prog (.*);
   synth_host i_synth_host (.*);
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // Reference model compare; -1 marks a register never loaded
   task automatic check_all();
      int v, m, c;
      v = regs[0];
      m = regs[3];
      c = regs[6] << 1; // Data bit n lands in control bit n+1
      `CHK(program_error_n, err_exp)
      `CHK(video_select, 2'b00)
      `CHK(standby_code, 4'(regs[4]))
      `CHK(duty_trim_n, c[17])
      `CHK(change_mux_sel, c[20])
      `CHK(timeout_double, c[19])
      `CHK(prescale_sel, 3'(c >> 13))
      `CHK(video_prescale_x4, {3{c[13]}})
      `CHK(pd_mode_sel, c[21])
      if (v >= 0) begin
         `CHK(video_fb_div, 8'(((v >> 10) & 127) + 3))
         `CHK(video_ref_div, 8'((v & 127) + 2))
         `CHK(video_out_div_log2, 3'(v >> 7))
         `CHK(video_off, 1'((v >> 17) == 14))
         `CHK(video_from_memory, 1'((v >> 17) == 15))
      end
      if (m >= 0) begin
         `CHK(memory_fb_div, 8'(((m >> 10) & 127) + 3))
         `CHK(memory_ref_div, 8'((m & 127) + 2))
         `CHK(memory_out_div_log2, 3'(m >> 7))
      end
   endtask
   // Full transfer; only a valid unlock outside power-down takes effect
   task automatic load(input int a, input int d, input int ones);
      logic ok;
      ok = ones >= 5 && powerdown_n === 1'b1;
      i_synth_host.unlock(ones);
      i_synth_host.frame({d[20:0], a[2:0]}, 24);
      i_synth_host.coded(1'b1, 1'b1);
      if (ok && a != 5 && a != 7) regs[a] = d & 'h1fffff;
      if (ok) err_exp = 1'b1;
      if (ok && a == 3) `CHK(ref_on_memory, 1'b1)
      if (ok && a == 0) `CHK(ref_on_video, 1'b1)
      check_all();
      i_synth_host.idle();
   endtask
   task automatic summarize();
      $display("checks=%0d errors=%0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Hang guard
   initial begin
      repeat (60000) @(posedge clk_sys);
      err_count++;
      summarize();
   end
   // ==========================================================
   // Main sequence
   initial begin
      rst = 1'b1;
      powerdown_n = 1'b1;
      err_count = 0;
      check_count = 0;
      regs = '{default: -1};
      regs[4] = 8;
      regs[6] = 'h10000;
      err_exp = 1'b1;
      void'($urandom(50));
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys) rst = 1'b0;
      @(negedge clk_sys);
      `CHK(pd_mode_sel, 1'b0)
      `CHK(ref_on_video, 1'b0)
      `CHK(ref_on_memory, 1'b0)
      check_all();
      // Every address twice, reserved control bits kept clear
      for (int i = 0; i < 16; i++)
         load(i % 8, $urandom & ((i % 8 == 6) ? 'h1d7fff : 'h1fffff), 5 + i % 3);
      load(0, 'h1c0000 | ($urandom & 'h1ffff), 5);
      load(0, 'h1e0000 | ($urandom & 'h1ffff), 6);
      load(0, 'h1fffff, 5);
      load(3, 'h1fffff, 7);
      // Four high rises are too few to unlock
      load(3, 0, 4);
      @(negedge clk_sys) powerdown_n = 1'b0;
      load(4, 3, 5);
      @(negedge clk_sys) powerdown_n = 1'b1;
      // Bad start, bad complement, short word, overlong word
      for (int k = 0; k < 4; k++) begin
         i_synth_host.unlock(5);
         if (k == 0) i_synth_host.coded(1'b0, 1'b1);
         else i_synth_host.frame(24'h0, (k == 2) ? 10 : (k == 3) ? 24 : 0);
         if (k == 1) i_synth_host.coded(1'b0, 1'b0);
         if (k == 2) i_synth_host.coded(1'b1, 1'b1);
         if (k == 3) i_synth_host.coded(1'b0, 1'b1);
         err_exp = 1'b0;
         `CHK(program_error_n, 1'b0)
         i_synth_host.coded(1'b1, 1'b0);
         `CHK(program_error_n, 1'b0)
         i_synth_host.idle();
         load(k, $urandom & 'h1fffff, 5);
      end
      summarize();
   end
endmodule
